//--- design/adcofs_top.sv
// Output format and startup stage of an 8-bit pipelined converter.
// Assumes raw offset-binary results arrive with a sample strobe on clk.
// Operation
// - Format select low: output result as unsigned offset binary.
// - Format select high: two's complement, offset binary with msb inverted.
// - Outputs invalid until 20 sample cycles ran after power-up.
// - Positive full scale: all ones, or zero then seven ones.
// - Negative full scale: all zeros, or one then seven zeros.
// - Codes saturate at plus and minus full scale.
`timescale 1ns/1ps
module adcofs_top import adcofs_pkg::*; #(
    parameter int LATENCY = ADCOFS_DEF_LATENCY,
    parameter int DEPTH = ADCOFS_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sample_stb,
    input wire logic [ADCOFS_MSB:0] raw_code,
    input wire logic output_format_select,
    output logic out_valid,
    input wire logic out_ready,
    output logic [ADCOFS_MSB:0] out_code,
    output logic in_ready,
    output logic warm_done
);
    localparam int CW = $clog2(ADCOFS_STARTUP_CYCLES + 1);

    // ========================================
    // State
    typedef struct packed {
        logic [2:0] fmt_sync;
        logic fmt;
        adcofs_state_t state;
        logic [CW-1:0] warm_cnt;
        logic [LATENCY-1:0][ADCOFS_MSB+1:0] pipe;
        logic ov;
        logic [ADCOFS_MSB:0] oc;
        logic ir;
        logic wd;
    } adcofs_st_t;

    adcofs_st_t st_ff;
    adcofs_st_t nxt_st;
    logic f_valid;
    logic f_ready;
    logic [ADCOFS_MSB:0] f_data;
    logic f_in_ready;
    logic take_out;
    logic [ADCOFS_MSB+1:0] tail;

    assign tail = st_ff.pipe[LATENCY-1];
    assign take_out = !st_ff.ov || out_ready;
    assign f_ready = take_out;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.fmt_sync = {st_ff.fmt_sync[1:0], output_format_select};
        if (st_ff.fmt_sync[2] == st_ff.fmt_sync[1]) begin
            nxt_st.fmt = st_ff.fmt_sync[2];
        end
        nxt_st.ir = f_in_ready;
        // Raw codes are already clamped by the converter at full scale.
        if (sample_stb) begin
            nxt_st.pipe[0] = {1'b1, raw_code};
            for (int i = 1; i < LATENCY; i++) begin
                nxt_st.pipe[i] = st_ff.pipe[i-1];
            end
        end
        case (st_ff.state)
            ADCOFS_ST_WARMUP: begin
                if (sample_stb) begin
                    nxt_st.warm_cnt = st_ff.warm_cnt + CW'(1);
                    if (st_ff.warm_cnt == CW'(ADCOFS_STARTUP_CYCLES - 1)) begin
                        nxt_st.state = ADCOFS_ST_RUN;
                    end
                end
            end
            ADCOFS_ST_RUN: begin
                nxt_st.warm_cnt = st_ff.warm_cnt;
            end
            default: begin
                nxt_st.state = ADCOFS_ST_WARMUP;
            end
        endcase
        nxt_st.wd = nxt_st.state == ADCOFS_ST_RUN;
        if (take_out) begin
            nxt_st.ov = f_valid;
            if (f_valid) begin
                nxt_st.oc = adcofs_format(f_data, st_ff.fmt);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ========================================
    // Buffer; only words past warm-up and the pipeline latency enter.
    adcofs_fifo #(.WIDTH(ADCOFS_RESULT_W), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_valid(sample_stb && tail[ADCOFS_MSB+1] && st_ff.state == ADCOFS_ST_RUN),
        .in_ready(f_in_ready),
        .in_data(tail[ADCOFS_MSB:0]),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    assign out_valid = st_ff.ov;
    assign out_code = st_ff.oc;
    assign in_ready = st_ff.ir;
    assign warm_done = st_ff.wd;

    // ========================================
    // Startup checks
    property p_no_early;
        @(posedge clk) disable iff (!rstn)
        st_ff.state == ADCOFS_ST_WARMUP |-> !u_fifo.push;
    endproperty
    a_no_early: assert property (p_no_early) else $error("word accepted during warm-up");

    property p_warm_count;
        @(posedge clk) disable iff (!rstn)
        $rose(warm_done) |-> st_ff.warm_cnt == CW'(ADCOFS_STARTUP_CYCLES);
    endproperty
    a_warm_count: assert property (p_warm_count) else $error("warm-up length wrong");

    property p_warm_bound;
        @(posedge clk) disable iff (!rstn)
        st_ff.warm_cnt <= CW'(ADCOFS_STARTUP_CYCLES);
    endproperty
    a_warm_bound: assert property (p_warm_bound) else $error("warm-up counter ran past its end");

    // Only a reset returns the stage to warm-up.
    property p_warm_stays;
        @(posedge clk) disable iff (!rstn)
        warm_done |=> warm_done;
    endproperty
    a_warm_stays: assert property (p_warm_stays) else $error("warm-up flag dropped");

    property p_valid_warm;
        @(posedge clk) disable iff (!rstn)
        out_valid |-> warm_done;
    endproperty
    a_valid_warm: assert property (p_valid_warm) else $error("valid word before warm-up ended");

    // ========================================
    // Format checks
    property p_fmt_ob;
        @(posedge clk) disable iff (!rstn)
        take_out && f_valid && !st_ff.fmt |=> out_code == $past(f_data);
    endproperty
    a_fmt_ob: assert property (p_fmt_ob) else $error("offset binary word wrong");

    property p_fmt_tc;
        @(posedge clk) disable iff (!rstn)
        take_out && f_valid && st_ff.fmt |=> out_code == ($past(f_data) ^ ADCOFS_CODE_MID);
    endproperty
    a_fmt_tc: assert property (p_fmt_tc) else $error("two's complement word wrong");

    // A new select level is only used once the last two synchroniser stages agree.
    property p_fmt_sync;
        @(posedge clk) disable iff (!rstn)
        $changed(st_ff.fmt) |-> $past(st_ff.fmt_sync[2]) == $past(st_ff.fmt_sync[1]);
    endproperty
    a_fmt_sync: assert property (p_fmt_sync) else $error("format changed before the synchroniser settled");

    property p_pos_fs_ob;
        @(posedge clk) disable iff (!rstn)
        take_out && f_valid && f_data == ADCOFS_CODE_POS_FS && !st_ff.fmt |=> out_code == ADCOFS_CODE_POS_FS;
    endproperty
    a_pos_fs_ob: assert property (p_pos_fs_ob) else $error("positive full scale wrong");

    property p_pos_fs_tc;
        @(posedge clk) disable iff (!rstn)
        take_out && f_valid && f_data == ADCOFS_CODE_POS_FS && st_ff.fmt
            |=> out_code == (ADCOFS_CODE_POS_FS ^ ADCOFS_CODE_MID);
    endproperty
    a_pos_fs_tc: assert property (p_pos_fs_tc) else $error("positive full scale wrong");

    property p_neg_fs_ob;
        @(posedge clk) disable iff (!rstn)
        take_out && f_valid && f_data == ADCOFS_CODE_NEG_FS && !st_ff.fmt |=> out_code == ADCOFS_CODE_NEG_FS;
    endproperty
    a_neg_fs_ob: assert property (p_neg_fs_ob) else $error("negative full scale wrong");

    property p_neg_fs_tc;
        @(posedge clk) disable iff (!rstn)
        take_out && f_valid && f_data == ADCOFS_CODE_NEG_FS && st_ff.fmt
            |=> out_code == (ADCOFS_CODE_NEG_FS ^ ADCOFS_CODE_MID);
    endproperty
    a_neg_fs_tc: assert property (p_neg_fs_tc) else $error("negative full scale wrong");

    property p_mid_ob;
        @(posedge clk) disable iff (!rstn)
        take_out && f_valid && f_data == ADCOFS_CODE_MID && !st_ff.fmt |=> out_code == ADCOFS_CODE_MID;
    endproperty
    a_mid_ob: assert property (p_mid_ob) else $error("midscale word wrong");

    property p_mid_tc;
        @(posedge clk) disable iff (!rstn)
        take_out && f_valid && f_data == ADCOFS_CODE_MID && st_ff.fmt |=> out_code == '0;
    endproperty
    a_mid_tc: assert property (p_mid_tc) else $error("midscale word wrong");

    // ========================================
    // Flow checks
    property p_hold;
        @(posedge clk) disable iff (!rstn)
        out_valid && !out_ready |=> out_valid && $stable(out_code);
    endproperty
    a_hold: assert property (p_hold) else $error("output not held");

    // A taken word is followed at once by the next one while the buffer holds more.
    property p_next_word;
        @(posedge clk) disable iff (!rstn)
        out_valid && out_ready && f_valid |=> out_valid;
    endproperty
    a_next_word: assert property (p_next_word) else $error("gap between buffered words");

    property p_pipe_entry;
        @(posedge clk) disable iff (!rstn)
        sample_stb |=> st_ff.pipe[0] == {1'b1, $past(raw_code)};
    endproperty
    a_pipe_entry: assert property (p_pipe_entry) else $error("pipe entry");
endmodule // adcofs_top

//--- design/adcofs_pkg.sv
// Package for the converter output format and startup stage.
// Assumes one 20 MHz clock and no software-visible registers.
package adcofs_pkg;

    // ========================================
    // Widths and formats
    localparam int ADCOFS_RESULT_W = 8;
    localparam int ADCOFS_MSB = ADCOFS_RESULT_W - 1;
    localparam logic [7:0] ADCOFS_CODE_POS_FS = 8'hff;
    localparam logic [7:0] ADCOFS_CODE_NEG_FS = 8'h00;
    localparam logic [7:0] ADCOFS_CODE_MID = 8'h80;

    // ========================================
    // Timing
    localparam int ADCOFS_STARTUP_CYCLES = 20;
    localparam int ADCOFS_DEF_LATENCY = 5;
    localparam int ADCOFS_FIFO_DEPTH = 16;
    localparam int ADCOFS_CLK_HZ = 20000000;
    localparam int ADCOFS_MIN_RATE_SPS = 1000000;
    // Longest allowed sample period in clk cycles, rounded down.
    localparam int ADCOFS_MAX_GAP_CYCLES = ADCOFS_CLK_HZ / ADCOFS_MIN_RATE_SPS;

    // ========================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic [ADCOFS_MSB:0] code;
    } adcofs_word_t;

    typedef enum logic [1:0] {
        ADCOFS_ST_WARMUP = 2'b00,
        ADCOFS_ST_RUN = 2'b01
    } adcofs_state_t;

    // Offset binary to two's complement when selected.
    function automatic logic [ADCOFS_MSB:0] adcofs_format(input logic [ADCOFS_MSB:0] ob, input logic twos);
        adcofs_format = {ob[ADCOFS_MSB] ^ twos, ob[ADCOFS_MSB-1:0]};
    endfunction

endpackage

//--- design/adcofs_fifo.sv
// Synchronous FIFO of flip-flops with valid/ready on both sides.
// Assumes a single clock and active-low asynchronous reset.
`timescale 1ns/1ps
module adcofs_fifo import adcofs_pkg::*; #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } adcofs_fifo_t;

    adcofs_fifo_t st_ff;
    adcofs_fifo_t nxt_st;
    logic push;
    logic pop;

    assign in_ready = (st_ff.cnt != (AW+1)'(DEPTH)) || pop;
    assign out_valid = st_ff.cnt != '0;
    assign out_data = st_ff.mem[st_ff.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr] = in_data;
            nxt_st.wr = st_ff.wr + AW'(1);
        end
        if (pop) begin
            nxt_st.rd = st_ff.rd + AW'(1);
        end
        nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    property p_no_overflow;
        @(posedge clk) disable iff (!rstn)
        st_ff.cnt <= (AW+1)'(DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("fifo count exceeds depth");
endmodule // adcofs_fifo

//--- verification/adcofs_src.sv
// Model of the capture logic that paces converter samples into the stage.
// Assumes the bench clk at 20 MHz; each strobe stands for one sample clock.
`timescale 1ns/1ps
module adcofs_src import adcofs_pkg::*; (
    input wire logic clk,
    output logic sample_stb,
    output logic [ADCOFS_MSB:0] raw_code
);
    initial begin
        sample_stb = 1'b0;
        raw_code = 8'h00;
    end

    // ========================================
    // Sample pacing
    // One strobe every second clk gives 10 MSPS at an even duty.
    task automatic burst(input logic [ADCOFS_MSB:0] c, input int n);
        for (int i = 0; i < n; i++) begin
            sample_stb <= 1'b1;
            raw_code <= c;
            @(posedge clk);
            sample_stb <= 1'b0;
            // Between strobes the bus carries no sample, so it shows the inverse.
            raw_code <= ~c;
            @(posedge clk);
        end
    endtask
endmodule // adcofs_src

//--- verification/testbench.sv
// Self-checking bench for the output format and startup stage.
// Assumes the partner model paces samples and this bench consumes words.
`timescale 1ns/1ps
module testbench import adcofs_pkg::*;;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic fmt = 1'b0;
    logic rdy = 1'b1;
    logic stb;
    logic [7:0] raw;
    logic out_valid;
    logic [7:0] out_code;
    logic in_ready;
    logic warm_done;
    int n_errors = 0;
    int n_compared = 0;
    int n_rx = 0;
    logic [7:0] last_rx = 8'h00;

    always #25 clk = ~clk;

    adcofs_src src (.clk(clk), .sample_stb(stb), .raw_code(raw));
    adcofs_top #(.LATENCY(ADCOFS_DEF_LATENCY), .DEPTH(ADCOFS_FIFO_DEPTH)) dut (.clk(clk), .rstn(rstn),
        .sample_stb(stb), .raw_code(raw),
        .output_format_select(fmt), .out_valid(out_valid), .out_ready(rdy), .out_code(out_code),
        .in_ready(in_ready), .warm_done(warm_done));

    // Only words flagged valid are kept by the capture side.
    always @(posedge clk) begin
        if (out_valid === 1'b1 && rdy === 1'b1) begin
            n_rx <= n_rx + 1;
            last_rx <= out_code;
        end
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task test_done;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ========================================
    // Scenarios
    task t_warmup;
        for (int i = 0; i < 19; i++) src.burst(8'h80, 1);
        check({7'h00, warm_done}, 8'h00);
        check({7'h00, out_valid}, 8'h00);
        check(8'(n_rx), 8'h00);
        src.burst(8'h80, 1);
        check({7'h00, warm_done}, 8'h01);
    endtask

    task t_format(input logic [7:0] c, input logic f, input logic [7:0] exp);
        int n0;
        fmt <= f;
        repeat (8) @(posedge clk);
        n0 = n_rx;
        src.burst(c, 12);
        repeat (8) @(posedge clk);
        check(last_rx, exp);
        check(8'(n_rx - n0), 8'h0c);
    endtask

    // With the consumer stalled the stage keeps one word in its output and its depth in the buffer and
    // drops the rest; samples keep coming while it drains, so the sample rate never falls too low.
    task t_fill;
        int n0;
        n0 = n_rx;
        rdy <= 1'b0;
        src.burst(8'h3c, 25);
        check({7'h00, in_ready}, 8'h00);
        check(8'(n_rx - n0), 8'h00);
        rdy <= 1'b1;
        src.burst(8'h3c, 20);
        repeat (4) @(posedge clk);
        check(8'(n_rx - n0), 8'(ADCOFS_FIFO_DEPTH + 1 + 20));
        check(last_rx, 8'h3c);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_warmup();
        t_format(8'hff, 1'b0, 8'hff);
        t_format(8'hff, 1'b1, 8'h7f);
        t_format(8'h00, 1'b0, 8'h00);
        t_format(8'h00, 1'b1, 8'h80);
        t_format(8'h80, 1'b1, 8'h00);
        t_format(8'h5a, 1'b1, 8'hda);
        t_format(8'h5a, 1'b0, 8'h5a);
        t_fill();
        test_done();
    end

    // Whole run needs well under a thousand cycles.
    initial begin
        repeat (2000) @(posedge clk);
        n_errors++;
        test_done();
    end
endmodule // testbench
